// ---- design/cpis_core.sv ----
// Instruction execution and power-mode control for the 16-bit core.
module cpis_core #(
	parameter int N_PERIPH = 8,
	parameter int RTC_WAKE_CYCLES = cpis_pkg::RTC_WAKE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	output logic op_ready,
	input wire logic [15:0] first_word,
	input wire logic ext_valid,
	output logic ext_ready,
	input wire logic [15:0] ext_word,
	input wire logic [15:0] operand_a,
	input wire logic [15:0] operand_b,
	input wire logic carry_in,
	input wire logic bit_in,
	input wire logic irq_pending,
	input wire logic ext_int_pin,
	input wire logic nmi_pin,
	input wire logic rtc_keep_running,
	input wire logic rtc_wake_enable,
	input wire logic [N_PERIPH-1:0] peripheral_disable_reg,
	input wire logic [N_PERIPH-1:0] periph_active,
	output logic [2:0] instr_len,
	output logic [15:0] res_word,
	output logic res_we,
	output logic carry_flag,
	output logic zero_flag,
	output logic div_error,
	output logic [15:0] mul_div_high,
	output logic [15:0] quotient_low_reg,
	output logic branch_taken,
	output logic [15:0] branch_offset,
	output logic bit_we,
	output logic bit_val,
	output logic push_en,
	output logic [15:0] push_data,
	output logic call_en,
	output logic [15:0] call_target,
	output logic trap_en,
	output logic [6:0] trap_number,
	output cpis_pkg::cpis_pwr_type pwr_mode,
	output logic cpu_clk_en,
	output logic [N_PERIPH-1:0] periph_clk_en,
	output logic rtc_clk_en,
	output logic rtc_wake
);

	// ****************************************************************
	// Pin synchronisers and length decode.
	// ****************************************************************
	logic ext_int_sync;
	logic nmi_sync;
	logic [2:0] dec_len;
	logic dec_needs_ext;

	cpis_sync2 u_sync_ext_int (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_async(ext_int_pin),
		.pin_sync(ext_int_sync)
	);

	cpis_sync2 u_sync_nmi (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_async(nmi_pin),
		.pin_sync(nmi_sync)
	);

	cpis_len_decode u_len (
		.first_word(first_word),
		.len_bytes(dec_len),
		.needs_ext(dec_needs_ext)
	);

	// ****************************************************************
	// Fetch sequencing.
	// ****************************************************************
	cpis_pkg::cpis_fetch_type fstate;
	cpis_pkg::cpis_fetch_type next_fstate;
	logic [15:0] held_word;
	logic [15:0] next_held_word;
	logic exec_fire;
	logic [15:0] iw;
	logic [15:0] xw;

	// Handshakes; the core takes nothing outside run mode.
	assign op_ready = (pwr_mode == cpis_pkg::pwr_run) &&
		(fstate == cpis_pkg::fetch_first);
	assign ext_ready = (pwr_mode == cpis_pkg::pwr_run) &&
		(fstate == cpis_pkg::fetch_ext);

	// A short instruction runs at once, a long one waits for its operand.
	always_comb begin
		next_fstate = fstate;
		next_held_word = held_word;
		exec_fire = 1'b0;
		iw = first_word;
		xw = ext_word;
		case (fstate)
			cpis_pkg::fetch_first: begin
				if (op_valid && op_ready) begin
					next_held_word = first_word;
					if (dec_needs_ext) begin
						next_fstate = cpis_pkg::fetch_ext;
					end else begin
						exec_fire = 1'b1;
					end
				end
			end
			cpis_pkg::fetch_ext: begin
				iw = held_word;
				if (ext_valid && ext_ready) begin
					exec_fire = 1'b1;
					next_fstate = cpis_pkg::fetch_first;
				end
			end
			default: begin
				next_fstate = cpis_pkg::fetch_first;
			end
		endcase
	end

	// Fetch state registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fstate <= cpis_pkg::fetch_first;
			held_word <= cpis_pkg::WORD_RESET;
		end else begin
			fstate <= next_fstate;
			held_word <= next_held_word;
		end
	end

	// ****************************************************************
	// Execution.
	// ****************************************************************
	cpis_pkg::cpis_op_type op;
	logic var_a;
	logic var_b;
	logic [15:0] opb;
	logic [16:0] sum_w;
	logic [8:0] sum_b;
	logic [31:0] prod;
	logic [31:0] pair_q;
	logic [31:0] pair_r;
	logic [15:0] byte_mask;
	logic [15:0] byte_data;
	logic [2:0] next_instr_len;
	logic [15:0] next_res_word;
	logic next_res_we;
	logic next_carry_flag;
	logic next_zero_flag;
	logic next_div_error;
	logic [15:0] next_mul_div_high;
	logic [15:0] next_quotient_low_reg;
	logic next_branch_taken;
	logic [15:0] next_branch_offset;
	logic next_bit_we;
	logic next_bit_val;
	logic next_push_en;
	logic [15:0] next_push_data;
	logic next_call_en;
	logic [15:0] next_call_target;
	logic next_trap_en;
	logic [6:0] next_trap_number;

	// Shift steps needed to bring the top set bit to position 15.
	function automatic logic [15:0] norm_steps(input logic [15:0] w);
		logic [15:0] cnt;
		logic found;
		cnt = cpis_pkg::WORD_RESET;
		found = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (!found && w[i]) begin
				found = 1'b1;
				cnt = 16'(15 - i);
			end
		end
		return cnt;
	endfunction

	// Operation results; pulses default low, held values keep their state.
	always_comb begin
		op = cpis_pkg::cpis_op_type'(iw[cpis_pkg::OP_MSB:cpis_pkg::OP_LSB]);
		var_a = iw[cpis_pkg::VAR_A_BIT];
		var_b = iw[cpis_pkg::VAR_B_BIT];
		opb = (dec_len == cpis_pkg::LEN_LONG || fstate ==
			cpis_pkg::fetch_ext) ? xw : operand_b;
		sum_w = 17'h0_0000;
		sum_b = 9'h000;
		prod = 32'h0000_0000;
		pair_q = 32'h0000_0000;
		pair_r = 32'h0000_0000;
		byte_mask = 16'h0000;
		byte_data = 16'h0000;
		next_instr_len = instr_len;
		next_res_word = res_word;
		next_res_we = 1'b0;
		next_carry_flag = carry_flag;
		next_zero_flag = zero_flag;
		next_div_error = 1'b0;
		next_mul_div_high = mul_div_high;
		next_quotient_low_reg = quotient_low_reg;
		next_branch_taken = 1'b0;
		next_branch_offset = branch_offset;
		next_bit_we = 1'b0;
		next_bit_val = bit_val;
		next_push_en = 1'b0;
		next_push_data = push_data;
		next_call_en = 1'b0;
		next_call_target = call_target;
		next_trap_en = 1'b0;
		next_trap_number = trap_number;
		if (exec_fire) begin
			next_instr_len = (fstate == cpis_pkg::fetch_ext) ?
				cpis_pkg::LEN_LONG : cpis_pkg::LEN_SHORT;
			case (op)
				cpis_pkg::op_add_with_carry,
				cpis_pkg::op_subtract_with_carry: begin
					if (op == cpis_pkg::op_add_with_carry) begin
						sum_w = {1'b0, operand_a} + {1'b0, opb} +
							{16'h0000, carry_in};
						sum_b = {1'b0, operand_a[7:0]} + {1'b0, opb[7:0]} +
							{8'h00, carry_in};
					end else begin
						sum_w = {1'b0, operand_a} - {1'b0, opb} -
							{16'h0000, carry_in};
						sum_b = {1'b0, operand_a[7:0]} - {1'b0, opb[7:0]} -
							{8'h00, carry_in};
					end
					next_res_we = 1'b1;
					if (var_a) begin
						next_res_word = {operand_a[15:8], sum_b[7:0]};
						next_carry_flag = sum_b[8];
						next_zero_flag = (sum_b[7:0] == 8'h00);
					end else begin
						next_res_word = sum_w[15:0];
						next_carry_flag = sum_w[16];
						next_zero_flag = (sum_w[15:0] == 16'h0000);
					end
				end
				cpis_pkg::op_multiply: begin
					prod = var_a ? 32'(operand_a) * 32'(operand_b) :
						32'($signed(operand_a) * $signed(operand_b));
					next_mul_div_high = prod[31:16];
					next_quotient_low_reg = prod[15:0];
					next_zero_flag = (prod == 32'h0000_0000);
				end
				cpis_pkg::op_short_divide,
				cpis_pkg::op_long_divide: begin
					if (operand_b == 16'h0000) begin
						next_div_error = 1'b1;
					end else if (op == cpis_pkg::op_short_divide) begin
						if (var_a) begin
							next_quotient_low_reg = quotient_low_reg /
								operand_b;
							next_mul_div_high = quotient_low_reg % operand_b;
						end else begin
							next_quotient_low_reg = 16'($signed(
								quotient_low_reg) / $signed(operand_b));
							next_mul_div_high = 16'($signed(quotient_low_reg)
								% $signed(operand_b));
						end
					end else begin
						if (var_a) begin
							pair_q = {mul_div_high, quotient_low_reg} /
								{16'h0000, operand_b};
							pair_r = {mul_div_high, quotient_low_reg} %
								{16'h0000, operand_b};
						end else begin
							pair_q = 32'($signed({mul_div_high,
								quotient_low_reg}) / $signed({{16{operand_b[15]}},
								operand_b}));
							pair_r = 32'($signed({mul_div_high,
								quotient_low_reg}) % $signed({{16{operand_b[15]}},
								operand_b}));
						end
						next_quotient_low_reg = pair_q[15:0];
						next_mul_div_high = pair_r[15:0];
					end
				end
				cpis_pkg::op_compare_then_decrement,
				cpis_pkg::op_compare_then_increment: begin
					sum_w = {1'b0, operand_a} - {1'b0, opb};
					next_carry_flag = sum_w[16];
					next_zero_flag = (sum_w[15:0] == 16'h0000);
					next_res_we = 1'b1;
					if (op == cpis_pkg::op_compare_then_decrement) begin
						next_res_word = operand_a - (var_b ? 16'h0002 :
							16'h0001);
					end else begin
						next_res_word = operand_a + (var_b ? 16'h0002 :
							16'h0001);
					end
				end
				cpis_pkg::op_normalize_count: begin
					next_res_word = norm_steps(operand_a);
					next_res_we = 1'b1;
					next_zero_flag = (operand_a == 16'h0000);
				end
				cpis_pkg::op_masked_byte_field_modify: begin
					byte_mask = var_b ? {xw[cpis_pkg::MASK_MSB:
						cpis_pkg::MASK_LSB], 8'h00} : {8'h00,
						xw[cpis_pkg::MASK_MSB:cpis_pkg::MASK_LSB]};
					byte_data = var_b ? {xw[cpis_pkg::DATA_MSB:0], 8'h00} :
						{8'h00, xw[cpis_pkg::DATA_MSB:0]};
					next_res_word = (operand_a & ~byte_mask) |
						(byte_data & byte_mask);
					next_res_we = 1'b1;
				end
				cpis_pkg::op_bit_copy: begin
					next_bit_we = 1'b1;
					next_bit_val = bit_in ^ var_a;
				end
				cpis_pkg::op_jump_if_bit_one,
				cpis_pkg::op_jump_if_bit_zero: begin
					next_branch_offset = {{7{iw[cpis_pkg::OFFS_MSB]}},
						iw[cpis_pkg::OFFS_MSB:0], 1'b0};
					if (op == cpis_pkg::op_jump_if_bit_one && bit_in) begin
						next_branch_taken = 1'b1;
						next_bit_we = var_a;
						next_bit_val = 1'b0;
					end
					if (op == cpis_pkg::op_jump_if_bit_zero && !bit_in) begin
						next_branch_taken = 1'b1;
						next_bit_we = var_a;
						next_bit_val = 1'b1;
					end
				end
				cpis_pkg::op_push_then_call: begin
					next_push_en = 1'b1;
					next_push_data = operand_a;
					next_call_en = 1'b1;
					next_call_target = xw;
				end
				cpis_pkg::op_context_switch: begin
					next_push_en = 1'b1;
					next_push_data = operand_a;
					next_res_word = xw;
					next_res_we = 1'b1;
				end
				cpis_pkg::op_byte_to_word_extend: begin
					next_res_word = var_a ? {8'h00, opb[7:0]} :
						{{8{opb[7]}}, opb[7:0]};
					next_res_we = 1'b1;
				end
				cpis_pkg::op_arith_right_shift: begin
					next_res_word = 16'($signed(operand_a) >>>
						operand_b[cpis_pkg::SHAMT_MSB:0]);
					next_res_we = 1'b1;
				end
				cpis_pkg::op_trap: begin
					next_trap_en = 1'b1;
					next_trap_number = iw[cpis_pkg::TRAP_MSB:0];
				end
				default: begin
					next_res_we = 1'b0;
				end
			endcase
		end
	end

	// Execution result registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			instr_len <= cpis_pkg::LEN_SHORT;
			res_word <= cpis_pkg::WORD_RESET;
			res_we <= 1'b0;
			carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			div_error <= 1'b0;
			mul_div_high <= cpis_pkg::WORD_RESET;
			quotient_low_reg <= cpis_pkg::WORD_RESET;
			branch_taken <= 1'b0;
			branch_offset <= cpis_pkg::WORD_RESET;
			bit_we <= 1'b0;
			bit_val <= 1'b0;
			push_en <= 1'b0;
			push_data <= cpis_pkg::WORD_RESET;
			call_en <= 1'b0;
			call_target <= cpis_pkg::WORD_RESET;
			trap_en <= 1'b0;
			trap_number <= 7'h00;
		end else begin
			instr_len <= next_instr_len;
			res_word <= next_res_word;
			res_we <= next_res_we;
			carry_flag <= next_carry_flag;
			zero_flag <= next_zero_flag;
			div_error <= next_div_error;
			mul_div_high <= next_mul_div_high;
			quotient_low_reg <= next_quotient_low_reg;
			branch_taken <= next_branch_taken;
			branch_offset <= next_branch_offset;
			bit_we <= next_bit_we;
			bit_val <= next_bit_val;
			push_en <= next_push_en;
			push_data <= next_push_data;
			call_en <= next_call_en;
			call_target <= next_call_target;
			trap_en <= next_trap_en;
			trap_number <= next_trap_number;
		end
	end

	// ****************************************************************
	// Power modes and real-time clock wake-up.
	// ****************************************************************
	cpis_pkg::cpis_pwr_type next_pwr_mode;
	logic [31:0] rtc_count;
	logic [31:0] next_rtc_count;
	logic next_rtc_wake;

	// Clock enables follow the mode; peripherals also need activity.
	always_comb begin
		cpu_clk_en = (pwr_mode == cpis_pkg::pwr_run);
		rtc_clk_en = (pwr_mode == cpis_pkg::pwr_run) ||
			(pwr_mode == cpis_pkg::pwr_idle) || rtc_keep_running;
		for (int i = 0; i < N_PERIPH; i++) begin
			periph_clk_en[i] = ((pwr_mode == cpis_pkg::pwr_run) ||
				(pwr_mode == cpis_pkg::pwr_idle)) &&
				!peripheral_disable_reg[i] &&
				periph_active[i];
		end
	end

	// Mode transitions and the periodic wake-up counter.
	always_comb begin
		next_pwr_mode = pwr_mode;
		next_rtc_count = rtc_count;
		next_rtc_wake = 1'b0;
		if (rtc_clk_en && rtc_wake_enable) begin
			if (rtc_count >= 32'(RTC_WAKE_CYCLES - 1)) begin
				next_rtc_count = 32'h0000_0000;
				next_rtc_wake = 1'b1;
			end else begin
				next_rtc_count = rtc_count + 32'h0000_0001;
			end
		end
		case (pwr_mode)
			cpis_pkg::pwr_run: begin
				if (exec_fire && op == cpis_pkg::op_idle_entry) begin
					next_pwr_mode = cpis_pkg::pwr_idle;
				end else if (exec_fire && op == cpis_pkg::op_sleep_entry) begin
					next_pwr_mode = cpis_pkg::pwr_sleep;
				end else if (exec_fire && op ==
					cpis_pkg::op_power_down_entry && !nmi_sync) begin
					next_pwr_mode = cpis_pkg::pwr_down;
				end
			end
			cpis_pkg::pwr_idle: begin
				if (irq_pending || ext_int_sync || rtc_wake) begin
					next_pwr_mode = cpis_pkg::pwr_run;
				end
			end
			cpis_pkg::pwr_sleep: begin
				if (ext_int_sync || rtc_wake) begin
					next_pwr_mode = cpis_pkg::pwr_run;
				end
			end
			cpis_pkg::pwr_down: begin
				next_pwr_mode = cpis_pkg::pwr_down;
			end
			default: begin
				next_pwr_mode = cpis_pkg::pwr_run;
			end
		endcase
	end

	// Power mode and wake-up registers.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pwr_mode <= cpis_pkg::pwr_run;
			rtc_count <= 32'h0000_0000;
			rtc_wake <= 1'b0;
		end else begin
			pwr_mode <= next_pwr_mode;
			rtc_count <= next_rtc_count;
			rtc_wake <= next_rtc_wake;
		end
	end

endmodule // cpis_core

// ---- design/cpis_len_decode.sv ----
// Instruction length decoder working from the first word only.
module cpis_len_decode (
	input wire logic [15:0] first_word,
	output logic [2:0] len_bytes,
	output logic needs_ext
);

	cpis_pkg::cpis_op_type op;

	// Fixed-length classes ignore the long-form bit; mixed ones use it.
	always_comb begin
		op = cpis_pkg::cpis_op_type'(first_word[cpis_pkg::OP_MSB:
			cpis_pkg::OP_LSB]);
		case (op)
			cpis_pkg::op_add_with_carry,
			cpis_pkg::op_subtract_with_carry,
			cpis_pkg::op_compare_then_decrement,
			cpis_pkg::op_compare_then_increment,
			cpis_pkg::op_byte_to_word_extend: begin
				len_bytes = first_word[cpis_pkg::LONG_BIT] ?
					cpis_pkg::LEN_LONG : cpis_pkg::LEN_SHORT;
			end
			cpis_pkg::op_masked_byte_field_modify,
			cpis_pkg::op_bit_copy,
			cpis_pkg::op_jump_if_bit_one,
			cpis_pkg::op_jump_if_bit_zero,
			cpis_pkg::op_push_then_call,
			cpis_pkg::op_context_switch,
			cpis_pkg::op_idle_entry,
			cpis_pkg::op_sleep_entry,
			cpis_pkg::op_power_down_entry: begin
				len_bytes = cpis_pkg::LEN_LONG;
			end
			default: begin
				len_bytes = cpis_pkg::LEN_SHORT;
			end
		endcase
		needs_ext = (len_bytes == cpis_pkg::LEN_LONG);
	end

endmodule // cpis_len_decode

// ---- design/cpis_sync2.sv ----
// Two flip-flop synchroniser for a level arriving from a pin.
module cpis_sync2 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pin_async,
	output logic pin_sync
);

	logic stage_one;
	logic next_stage_one;
	logic next_pin_sync;

	// The first stage feeds only the second stage.
	always_comb begin
		next_stage_one = pin_async;
		next_pin_sync = stage_one;
	end

	// Both stages clear under reset.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage_one <= 1'b0;
			pin_sync <= 1'b0;
		end else begin
			stage_one <= next_stage_one;
			pin_sync <= next_pin_sync;
		end
	end

endmodule // cpis_sync2

// ---- pkg/cpis_pkg.sv ----
// Constants, field layout and types shared by the instruction and power core.
// Summary of operation
// - Idle stops CPU, peripherals keep clocking.
// - Sleep and power down stop all clocks, the RTC clock only when rtc_keep_running is low.
// - External interrupt ends sleep mode.
// - Each peripheral disabled independently via register.
// - Inactive logic clocks gated off automatically.
// - Real-time clock issues periodic wake-up events.
// - Add/subtract with carry, word or byte.
// - Signed or unsigned 16x16 multiply, 2 bytes.
// - Short divide quotient-low register by register.
// - Long divide 32-bit pair by register.
// - Compare then step register by one or two.
// - Normalize count written to another register.
// - Masked high/low byte field modify, 4 bytes.
// - Copy direct bit, optionally inverted.
// - Jump if bit one, optionally clear it.
// - Jump if bit zero, optionally set it.
// - Push register then call absolute subroutine.
// - Push register then load word operand.
// - Byte to word, sign or zero extend.
// - Arithmetic right shift replicates sign bit.
// - Trap calls routine by immediate number.
package cpis_pkg;

	// ****************************************************************
	// Widths and first-word, second-word and shift-count field positions.
	// ****************************************************************
	localparam int WORD_W = 16;
	localparam int OP_MSB = 15;
	localparam int OP_LSB = 10;
	localparam int VAR_A_BIT = 9;
	localparam int VAR_B_BIT = 8;
	localparam int LONG_BIT = 7;
	localparam int OFFS_MSB = 7;
	localparam int TRAP_MSB = 6;
	localparam int SHAMT_MSB = 3;
	localparam int MASK_MSB = 15;
	localparam int MASK_LSB = 8;
	localparam int DATA_MSB = 7;

	// ****************************************************************
	// Instruction lengths in bytes and reset values.
	// ****************************************************************
	localparam logic [2:0] LEN_SHORT = 3'h2;
	localparam logic [2:0] LEN_LONG = 3'h4;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// ****************************************************************
	// Timing: real-time clock wake-up period.
	// ****************************************************************
	localparam int CLK_MHZ = 40;
	localparam int RTC_WAKE_PERIOD_US = 1000;
	localparam int RTC_WAKE_CYCLES = RTC_WAKE_PERIOD_US * CLK_MHZ;

	// Operation classes held in the top six bits of the first word.
	typedef enum logic [5:0] {
		op_nop = 6'h00,
		op_add_with_carry = 6'h01,
		op_subtract_with_carry = 6'h02,
		op_multiply = 6'h03,
		op_short_divide = 6'h04,
		op_long_divide = 6'h05,
		op_compare_then_decrement = 6'h06,
		op_compare_then_increment = 6'h07,
		op_normalize_count = 6'h08,
		op_masked_byte_field_modify = 6'h09,
		op_bit_copy = 6'h0a,
		op_jump_if_bit_one = 6'h0b,
		op_jump_if_bit_zero = 6'h0c,
		op_push_then_call = 6'h0d,
		op_context_switch = 6'h0e,
		op_byte_to_word_extend = 6'h0f,
		op_arith_right_shift = 6'h10,
		op_trap = 6'h11,
		op_idle_entry = 6'h12,
		op_sleep_entry = 6'h13,
		op_power_down_entry = 6'h14
	} cpis_op_type;

	// Power saving modes.
	typedef enum logic [1:0] {
		pwr_run = 2'h0,
		pwr_idle = 2'h1,
		pwr_sleep = 2'h2,
		pwr_down = 2'h3
	} cpis_pwr_type;

	// Fetch sequencer states.
	typedef enum logic [0:0] {
		fetch_first = 1'h0,
		fetch_ext = 1'h1
	} cpis_fetch_type;

endpackage // cpis_pkg

// ---- verif/cpis_chk.sv ----
// Checker for the instruction and power ports of the core.
module cpis_chk #(
	parameter int N_PERIPH = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire logic op_ready,
	input wire logic ext_ready,
	input wire logic [15:0] first_word,
	input wire logic ext_int_pin,
	input wire logic rtc_keep_running,
	input wire logic [N_PERIPH-1:0] peripheral_disable_reg,
	input wire logic [N_PERIPH-1:0] periph_active,
	input wire logic [2:0] instr_len,
	input wire logic res_we,
	input wire logic trap_en,
	input wire logic [6:0] trap_number,
	input cpis_pkg::cpis_pwr_type pwr_mode,
	input wire logic cpu_clk_en,
	input wire logic [N_PERIPH-1:0] periph_clk_en,
	input wire logic rtc_clk_en,
	input wire logic rtc_wake
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic go;
	logic [5:0] cls;
	logic [N_PERIPH-1:0] allowed;
	// Taken first words, their class and the clocks peripherals may get.
	assign go = op_valid && op_ready;
	assign cls = first_word[15:10];
	assign allowed = periph_active & ~peripheral_disable_reg;
	AST_IDLE: assert property (pwr_mode == cpis_pkg::pwr_idle |->
		!cpu_clk_en && periph_clk_en == allowed)
		else $error("idle clocks wrong");
	AST_SLEEP: assert property (pwr_mode[1] |-> !cpu_clk_en &&
		periph_clk_en == '0 && rtc_clk_en == rtc_keep_running)
		else $error("sleep clocks wrong");
	AST_EXT_WAKE: assert property ((pwr_mode == cpis_pkg::pwr_sleep &&
		ext_int_pin) ##1 ext_int_pin [*3] |=> pwr_mode == cpis_pkg::pwr_run)
		else $error("no wake from sleep");
	AST_DISABLE: assert property ((periph_clk_en &
		peripheral_disable_reg) == '0) else $error("disabled unit clocked");
	AST_GATE: assert property ((periph_clk_en & ~periph_active) == '0)
		else $error("idle unit clocked");
	AST_RTC: assert property (rtc_wake |=> !rtc_wake [*6])
		else $error("wake pulses too close");
	AST_MUL: assert property (go && cls == 6'h03 |=>
		!res_we && !ext_ready && instr_len == 3'h2)
		else $error("multiply wrong");
	AST_LONG: assert property (go && cls == 6'h0a |=>
		ext_ready && !op_ready) else $error("second word not awaited");
	AST_TRAP: assert property (go && cls == 6'h11 |=> trap_en &&
		trap_number == $past(first_word[6:0])) else $error("trap wrong");
endmodule // cpis_chk

bind cpis_core cpis_chk #(.N_PERIPH(N_PERIPH)) u_chk (.*);

// ---- verif/cpu_instruction_set_power_modes_test.sv ----
// Self-checking bench for the instruction and power core.
module cpu_instruction_set_power_modes_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, rst_n = 0, op_valid = 0, ext_valid = 0;
	logic carry_in = 0, bit_in = 0, irq_pending = 0, ext_int_pin = 0;
	logic nmi_pin = 0, rtc_keep_running = 1, rtc_wake_enable = 0;
	logic [15:0] first_word = 0, ext_word = 0, operand_a = 0, operand_b = 0;
	logic [7:0] peripheral_disable_reg = 8'h0f, periph_active = 8'h3c;
	logic op_ready, ext_ready, res_we, carry_flag, zero_flag, div_error;
	logic branch_taken, bit_we, bit_val, push_en, call_en, trap_en;
	logic cpu_clk_en, rtc_clk_en, rtc_wake;
	logic [7:0] periph_clk_en;
	logic [2:0] instr_len;
	logic [6:0] trap_number;
	logic [15:0] res_word, mul_div_high, quotient_low_reg, branch_offset;
	logic [15:0] push_data, call_target, f, c, e;
	cpis_pkg::cpis_pwr_type pwr_mode;
	int failures = 0, cmp_count = 0, n = 0;
	// Rows: first word, operand a, operand b, carry in, expected result.
	localparam logic [79:0] ROWS [12] = '{
		{16'h0400, 16'h0001, 16'h0002, 16'h0001, 16'h0004},
		{16'h0600, 16'h12ff, 16'h0001, 16'h0001, 16'h1201},
		{16'h0800, 16'h0005, 16'h0002, 16'h0001, 16'h0002},
		{16'h1800, 16'h0010, 16'h0000, 16'h0000, 16'h000f},
		{16'h1900, 16'h0010, 16'h0000, 16'h0000, 16'h000e},
		{16'h1c00, 16'h0010, 16'h0000, 16'h0000, 16'h0011},
		{16'h1d00, 16'h0010, 16'h0000, 16'h0000, 16'h0012},
		{16'h2000, 16'h0001, 16'h0000, 16'h0000, 16'h000f},
		{16'h3c00, 16'h0000, 16'h0080, 16'h0000, 16'hff80},
		{16'h3e00, 16'h0000, 16'h0080, 16'h0000, 16'h0080},
		{16'h0a00, 16'h1200, 16'h0001, 16'h0001, 16'h12fe},
		{16'h4000, 16'h8000, 16'h0004, 16'h0000, 16'hf800}};

	cpis_core #(.RTC_WAKE_CYCLES(8)) DUT (.*);

	// The 40 MHz core clock.
	always #12.5 core_clk = ~core_clk;

	// Compares one result and reports a mismatch.
	task chk(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, g, x);
		end
	endtask

	// Offers a first word, and the second word for a long form.
	task op(input logic [15:0] fw, input logic [15:0] ew, input bit lng);
		@(negedge core_clk) first_word = fw;
		op_valid = 1;
		@(negedge core_clk) op_valid = 0;
		if (lng) begin
			ext_word = ew;
			ext_valid = 1;
			@(negedge core_clk) ext_valid = 0;
		end
	endtask

	// Prints the verdict and ends the run.
	task report_and_stop;
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#75000;
		failures++;
		report_and_stop;
	end

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial begin
		repeat (8) @(negedge core_clk);
		rst_n = 1;
		@(negedge core_clk);
		chk(instr_len, 3'h2);
		chk(op_ready & cpu_clk_en, 1'h1);
		chk(periph_clk_en, 8'h30);
		foreach (ROWS[i]) begin
			{f, operand_a, operand_b, c, e} = ROWS[i];
			carry_in = c[0];
			op(f, 16'h0000, 0);
			chk(res_word, e);
			chk(instr_len, 3'h2);
		end
		operand_a = 16'hffff;
		operand_b = 16'h0000;
		carry_in = 1;
		op(16'h0400, 16'h0000, 0);
		chk({res_we, carry_flag, zero_flag}, 3'h7);
		operand_a = 16'h0010;
		op(16'h1880, 16'h0003, 1);
		chk(res_word, 16'h000f);
		chk({carry_flag, zero_flag}, 2'h0);
		chk(instr_len, 3'h4);
		operand_a = 16'h0003;
		operand_b = 16'hfffe;
		op(16'h0c00, 16'h0000, 0);
		chk(quotient_low_reg, 16'hfffa);
		chk(mul_div_high, 16'hffff);
		op(16'h0e00, 16'h0000, 0);
		chk(mul_div_high, 16'h0002);
		operand_b = 16'h0002;
		op(16'h1200, 16'h0000, 0);
		chk(quotient_low_reg, 16'h7ffd);
		op(16'h1600, 16'h0000, 0);
		chk(quotient_low_reg, 16'h3ffe);
		chk(mul_div_high, 16'h0001);
		operand_b = 16'h0000;
		op(16'h1200, 16'h0000, 0);
		chk(div_error, 1'h1);
		bit_in = 1;
		op(16'h2a00, 16'h0000, 1);
		chk({bit_we, bit_val}, 2'h2);
		op(16'h2e03, 16'h0000, 1);
		chk({branch_taken, bit_we, bit_val}, 3'h6);
		chk(branch_offset, 16'h0006);
		bit_in = 0;
		op(16'h3203, 16'h0000, 1);
		chk({branch_taken, bit_we, bit_val}, 3'h7);
		operand_a = 16'h1234;
		op(16'h3400, 16'h0200, 1);
		chk({push_en, call_en}, 2'h3);
		chk(call_target, 16'h0200);
		chk(push_data, 16'h1234);
		op(16'h3800, 16'h5555, 1);
		chk({push_en, res_we}, 2'h3);
		chk(res_word, 16'h5555);
		op(16'h4405, 16'h0000, 0);
		chk({trap_en, trap_number}, 8'h85);
		op(16'h4800, 16'h0000, 1);
		chk({cpu_clk_en, periph_clk_en}, 9'h030);
		irq_pending = 1;
		repeat (3) @(negedge core_clk);
		chk(pwr_mode, 2'h0);
		irq_pending = 0;
		op(16'h4c00, 16'h0000, 1);
		chk({pwr_mode, cpu_clk_en, rtc_clk_en}, 4'h9);
		ext_int_pin = 1;
		repeat (5) @(negedge core_clk);
		chk(pwr_mode, 2'h0);
		ext_int_pin = 0;
		rtc_wake_enable = 1;
		repeat (32) @(negedge core_clk) n += rtc_wake;
		chk(16'(n), 16'h0004);
		op(16'h4c00, 16'h0000, 1);
		chk(pwr_mode, 2'h2);
		repeat (10) @(negedge core_clk);
		chk(pwr_mode, 2'h0);
		peripheral_disable_reg = 8'h00;
		nmi_pin = 1;
		repeat (3) @(negedge core_clk);
		chk(periph_clk_en, 8'h3c);
		op(16'h5000, 16'h0000, 1);
		chk(pwr_mode, 2'h0);
		nmi_pin = 0;
		repeat (3) @(negedge core_clk);
		op(16'h5000, 16'h0000, 1);
		chk({pwr_mode, periph_clk_en}, 10'h300);
		rst_n = 0;
		@(negedge core_clk) rst_n = 1;
		@(negedge core_clk);
		chk({pwr_mode, instr_len}, 5'h02);
		report_and_stop;
	end
endmodule // cpu_instruction_set_power_modes_test
